// [design/msd_map.vh]
// Contract
// - slot-sense low means lower slot
// - both boards fill outward from midpoint
// - top row mirrored between the slots
// - four rows of 64K words each
// - all access sources share one decode; refresh adds a video-picked row strobe
// - address captured into two duplicate latches
// - latch strobe toggles half rate, column strobe idle
// - board select from slot, bit20, bit19
// - board select gates only column strobes
// - bits 17,18 and slot decoded one-of-eight
// - row strobe zero from output 4/3
// - column strobes 0 and 1 decode table
// - column strobes 2 and 3 decode table
// - incoming row strobe routed to decoded row
// - refresh picks extra row from video bits
// - column strobe gated by board select
// - one column strobe, one row per access outside refresh
// - video access adds a refresh row strobe
`ifndef MSD_MAP_VH
`define MSD_MAP_VH
`define MSD_ROWS        4
`define MSD_ADDR_W      8
`define MSD_DEC_W       8
`define MSD_STROBE_IDLE 4'hf
`define MSD_DEC_ONE     8'h01
`define MSD_UPPER_BASE  4
`define MSD_LOWER_TOP   3
`define MSD_ADDR_RST    8'h00
`endif

// [design/msd_addr_latch.v]
`timescale 1ns/1ps
`include "msd_map.vh"
// one transparent address latch bank; instantiated twice to split matrix loading
module msd_addr_latch (
	input  wire                     clk,
	input  wire                     arst_n,
	input  wire                     latch_open,
	input  wire [`MSD_ADDR_W-1:0]   addr_in,
	output reg  [`MSD_ADDR_W-1:0]   addr_out
);
	// a clocked load stands in for transparency so the block keeps one clock
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_out <= `MSD_ADDR_RST;
		end else if (latch_open) begin
			addr_out <= addr_in;
		end
	end
endmodule // msd_addr_latch

// [design/msd_strobe_decode.v]
`timescale 1ns/1ps
`include "msd_map.vh"
// memory board address decode and strobe steering
module msd_strobe_decode (
	input  wire                     clk,
	input  wire                     arst_n,
	input  wire                     pixel_dot_clock,
	input  wire [`MSD_ADDR_W-1:0]   muxed_row_col_addr,
	input  wire                     row_strobe_n,
	input  wire                     col_strobe_n,
	input  wire                     slot_sense,
	input  wire                     addr_bit17,
	input  wire                     addr_bit18,
	input  wire                     addr_bit19,
	input  wire                     addr_bit20,
	input  wire                     refresh_enable_n,
	input  wire                     video_addr_bit8,
	input  wire                     video_addr_bit10,
	input  wire                     refresh_board_sel_a,
	input  wire                     refresh_board_sel_b,
	output reg                      addr_latch_strobe_n,
	output reg  [`MSD_ADDR_W-1:0]   matrix_addr_upper,
	output reg  [`MSD_ADDR_W-1:0]   matrix_addr_lower,
	output reg                      board_selected,
	output reg  [`MSD_ROWS-1:0]     matrix_row_strobe_n,
	output reg  [`MSD_ROWS-1:0]     matrix_col_strobe_n
);
	// one-of-eight decode of {slot, bit18, bit17}
	function [`MSD_DEC_W-1:0] dec8;
		input [2:0] sel;
		begin
			dec8 = `MSD_DEC_ONE << sel;
		end
	endfunction

	// matrix row whose strobes serve a given bit18/bit17 in this slot
	function [1:0] row_of;
		input       slot;
		input [1:0] hi_lo;
		begin
			row_of = slot ? hi_lo : ~hi_lo;
		end
	endfunction

	wire [`MSD_DEC_W-1:0] dec_w;
	wire [`MSD_ROWS-1:0]  row_en_w;
	wire [`MSD_ROWS-1:0]  refr_en_w;
	wire                  bsel_w;
	wire                  latch_open_w;
	wire [1:0]            row_idx_w;
	wire [`MSD_ADDR_W-1:0] lat_up_w;
	wire [`MSD_ADDR_W-1:0] lat_lo_w;
	reg                   dot_q_r;
	reg                   div_r;
	reg [`MSD_ROWS-1:0]   row_nxt;
	reg [`MSD_ROWS-1:0]   col_nxt;
	integer               i;

	// low slot-sense is the lower board, high the upper; each serves 512 KByte
	assign bsel_w = (~slot_sense & ~addr_bit20 & addr_bit19) |
	                (slot_sense & addr_bit20 & ~addr_bit19);
	assign dec_w = dec8({slot_sense, addr_bit18, addr_bit17});
	// output 4 in upper slot, output 3 in lower slot both land on row 0
	assign row_idx_w = row_of(slot_sense, {addr_bit18, addr_bit17});
	genvar g;
	generate
		for (g = 0; g < `MSD_ROWS; g = g + 1) begin : g_row
			// four matrix rows, each one 64K-word bank
			assign row_en_w[g] = slot_sense ? dec_w[`MSD_UPPER_BASE + g] : dec_w[`MSD_LOWER_TOP - g];
			assign refr_en_w[g] = ~refresh_enable_n &
			                      ({video_addr_bit10, video_addr_bit8} == g);
		end
	endgenerate

	// divide the dot clock by two, held asserted during column strobe
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dot_q_r <= 1'b0;
			div_r <= 1'b1;
		end else begin
			dot_q_r <= pixel_dot_clock;
			if (!col_strobe_n) begin
				div_r <= 1'b0;
			end else if (pixel_dot_clock & ~dot_q_r) begin
				div_r <= ~div_r;
			end
		end
	end
	assign latch_open_w = ~div_r;

	// two duplicate banks, upper and lower matrix halves
	msd_addr_latch u_lat_up (
		.clk        (clk),
		.arst_n     (arst_n),
		.latch_open (latch_open_w),
		.addr_in    (muxed_row_col_addr),
		.addr_out   (lat_up_w)
	);
	msd_addr_latch u_lat_lo (
		.clk        (clk),
		.arst_n     (arst_n),
		.latch_open (latch_open_w),
		.addr_in    (muxed_row_col_addr),
		.addr_out   (lat_lo_w)
	);

	// steering is combinational; only output flops follow it, as ports must be registered
	always @* begin
		row_nxt = `MSD_STROBE_IDLE;
		col_nxt = `MSD_STROBE_IDLE;
		for (i = 0; i < `MSD_ROWS; i = i + 1) begin
			// row strobe reaches the matrix regardless of board select
			row_nxt[i] = ~(~row_strobe_n & (row_en_w[i] | refr_en_w[i]));
		end
		// only the decoded column strobe, and only when selected
		if (!col_strobe_n && bsel_w) begin
			col_nxt[row_idx_w] = 1'b0;
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_latch_strobe_n <= 1'b1;
			matrix_addr_upper <= `MSD_ADDR_RST;
			matrix_addr_lower <= `MSD_ADDR_RST;
			board_selected <= 1'b0;
			matrix_row_strobe_n <= `MSD_STROBE_IDLE;
			matrix_col_strobe_n <= `MSD_STROBE_IDLE;
		end else begin
			addr_latch_strobe_n <= div_r;
			matrix_addr_upper <= lat_up_w;
			matrix_addr_lower <= lat_lo_w;
			board_selected <= bsel_w;
			matrix_row_strobe_n <= row_nxt;
			matrix_col_strobe_n <= col_nxt;
		end
	end
endmodule // msd_strobe_decode

// [verification/msd_strobe_decode_asserts.sv]
`timescale 1ns/1ps
module msd_asserts (
	input wire       clk,
	input wire       arst_n,
	input wire       row_strobe_n,
	input wire       col_strobe_n,
	input wire       slot_sense,
	input wire       addr_bit17,
	input wire       addr_bit18,
	input wire       addr_bit19,
	input wire       addr_bit20,
	input wire       refresh_enable_n,
	input wire       video_addr_bit8,
	input wire       video_addr_bit10,
	input wire       addr_latch_strobe_n,
	input wire       board_selected,
	input wire [3:0] matrix_row_strobe_n,
	input wire [3:0] matrix_col_strobe_n
);
	// expected steering from live inputs; the lower slot mirrors the row order
	wire [1:0] ix = {addr_bit18, addr_bit17} ^ {2{!slot_sense}};
	wire [1:0] vx = {video_addr_bit10, video_addr_bit8};
	wire [3:0] rx = 4'h1 << ix;
	wire       sl = slot_sense ? addr_bit20 & !addr_bit19 : !addr_bit20 & addr_bit19;
	wire [3:0] r = matrix_row_strobe_n;
	wire [3:0] c = matrix_col_strobe_n;
	reg        u_r;
	// low on the first edge after reset, whose past still holds reset-time inputs
	always @(posedge clk or negedge arst_n) u_r <= arst_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_sel; u_r |-> board_selected == $past(sl); endproperty
	a_sel: assert property (p_sel) else $error("sel");
	property p_col; u_r && !$past(col_strobe_n) && $past(sl) |-> c == ~$past(rx); endproperty
	a_col: assert property (p_col) else $error("col");
	property p_gate; u_r && !$past(sl) |-> c == 4'hf; endproperty
	a_gate: assert property (p_gate) else $error("gate");
	property p_cidle; u_r && $past(col_strobe_n) |-> c == 4'hf; endproperty
	a_cidle: assert property (p_cidle) else $error("cidle");
	property p_row; u_r && !$past(row_strobe_n) && $past(refresh_enable_n) |-> r == ~$past(rx); endproperty
	a_row: assert property (p_row) else $error("row");
	property p_ref; u_r && !$past(row_strobe_n) && !$past(refresh_enable_n) |-> !r[$past(vx)]; endproperty
	a_ref: assert property (p_ref) else $error("ref");
	property p_ridle; u_r && $past(row_strobe_n) |-> r == 4'hf; endproperty
	a_ridle: assert property (p_ridle) else $error("ridle");
	// the divider state and then the output flop each add a cycle before the strobe shows
	property p_hold; u_r && $past(u_r) && !$past(col_strobe_n, 2) |-> !addr_latch_strobe_n; endproperty
	a_hold: assert property (p_hold) else $error("hold");
endmodule // msd_asserts
bind msd_strobe_decode msd_asserts u_chk (.*);

// [verification/msd_proc_model.sv]
`timescale 1ns/1ps
// cpu-side timing: free dot clock, row then column address
module msd_proc_model (
	input wire       clk,
	output reg       pixel_dot_clock = 0,
	output reg [7:0] muxed_row_col_addr = 0,
	output reg       row_strobe_n = 1,
	output reg       col_strobe_n = 1
);
	// video timing never pauses, so the dot clock runs free
	always @(posedge clk) pixel_dot_clock <= !pixel_dot_clock;
	// address follows its strobe; a release shows the inverse, not stale data
	task step(input [2:0] s);
		@(posedge clk) {muxed_row_col_addr, row_strobe_n, col_strobe_n} <= {s[2] ? 8'ha5 : 8'h5a, s[1:0]};
	endtask
endmodule // msd_proc_model

// [verification/test_memory_board_strobe_decode.sv]
`timescale 1ns/1ps
`define CHK(a,e) begin checks_done++; if ((a)!==(e)) begin mismatches++; $display("BAD %0t %h %h",$time,a,e); end end
module test_memory_board_strobe_decode;
	reg clk=0, arst_n=0, slot_sense=0, addr_bit17=0, addr_bit18=0, addr_bit19=0, addr_bit20=0;
	reg refresh_enable_n=1, video_addr_bit8=0, video_addr_bit10=0, refresh_board_sel_a=1, refresh_board_sel_b=0;
	wire pixel_dot_clock, row_strobe_n, col_strobe_n, addr_latch_strobe_n, board_selected;
	wire [7:0] muxed_row_col_addr, matrix_addr_upper, matrix_addr_lower;
	wire [3:0] matrix_row_strobe_n, matrix_col_strobe_n;
	// slot, a20, a19, a18, a17, select, row strobes
	reg [9:0] tab [12] = '{10'h31e, 10'h33d, 10'h35b, 10'h377, 10'h0fe, 10'h0dd, 10'h0bb, 10'h097,
		10'h38e, 10'h007, 10'h20e, 10'h187};
	int mismatches=0, checks_done=0, i;
	msd_proc_model pm (.*);
	msd_strobe_decode uut (.*);
	initial forever #5 clk = !clk;
	task tally_and_finish;
		$display("%0d checks, %0d mismatches", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one full access: columns only reach the matrix on a selected board
	task run(input [9:0] t, input [3:0] e);
		@(posedge clk) {slot_sense, addr_bit20, addr_bit19, addr_bit18, addr_bit17} <= t[9:5];
		pm.step(3'h1);
		pm.step(3'h4);
		@(posedge clk) #1 `CHK(matrix_row_strobe_n, e)
		`CHK(matrix_col_strobe_n, t[4] ? t[3:0] : 4'hf)
		`CHK(board_selected, t[4])
		pm.step(3'h3);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 `CHK({matrix_row_strobe_n, matrix_col_strobe_n, board_selected, addr_latch_strobe_n}, 10'h3fd)
		@(posedge clk) arst_n <= 1;
		for (i = 0; i < 12; i++) run(tab[i], tab[i][3:0]);
		// refresh adds the video-picked row beside the addressed one
		@(posedge clk) refresh_enable_n <= 0;
		for (i = 0; i < 4; i++) begin
			@(posedge clk) {video_addr_bit10, video_addr_bit8} <= i[1:0];
			run(10'h31e, ~(4'h1 | 4'h1 << i));
		end
		repeat (5) @(posedge clk);
		#1 `CHK({matrix_addr_upper, matrix_addr_lower}, 16'h5a5a)
		tally_and_finish;
	end
endmodule // test_memory_board_strobe_decode
